// file: rtl/cascade_pkg.sv
package cascade_pkg;

   // Ring and loop limits
   localparam int RING_MAX_MODULES = 6;
   localparam int LOOP_COUNT       = 2;
   localparam int MUTE_W           = 16;

   // Register offsets (byte addresses, word index = offset / 4)
   localparam logic [7:0] OFS_CONFIG     = 8'h00;
   localparam logic [7:0] OFS_LOOP_FN    = 8'h04;
   localparam logic [7:0] OFS_TRANSIENT  = 8'h08;
   localparam logic [7:0] OFS_ZERO_DLY   = 8'h0C;
   localparam logic [7:0] OFS_START_DLY  = 8'h10;
   localparam logic [7:0] OFS_MAX_MUTE   = 8'h14;
   localparam logic [7:0] OFS_LIMIT_MUTE = 8'h18;
   localparam logic [7:0] OFS_STATUS     = 8'h2C;
   localparam int         LIMIT_SLOTS    = 5;

   // Config field positions
   localparam int CFG_MASTER_BIT      = 0;
   localparam int CFG_FIELDBUS_BIT    = 1;
   localparam int CFG_ENCODER_BIT     = 2;
   localparam int CFG_SLS_MUTE_EN_BIT = 3;
   localparam int CFG_MAX_MUTE_EN_BIT = 4;
   localparam int CFG_BRAKE_LSB       = 5;
   localparam int CFG_LOOP1_EN_BIT    = 7;
   localparam int CFG_AUTO_ACK_BIT    = 8;

   // Reset values
   localparam logic [31:0] CONFIG_RST    = 32'h0000_0080;
   localparam logic [MUTE_W-1:0] MUTE_RST = 16'h0019;

   // Safety functions a loop may carry
   typedef enum logic [3:0] {
      FN_TORQUE_REMOVAL, FN_RAMPED_STOP, FN_EMERGENCY_STOP, FN_SPEED_LIMIT_1,
      FN_DIR_POS, FN_DIR_NEG, FN_SPEED_LIMIT_2, FN_SPEED_LIMIT_3,
      FN_SPEED_LIMIT_4, FN_MONITOR_1, FN_MONITOR_2, FN_MONITOR_3,
      FN_MONITOR_4, FN_START_GUARD
   } safety_fn_e;

   // Brake timing against torque removal
   typedef enum logic [1:0] {
      BRAKE_BEFORE, BRAKE_WITH, BRAKE_AFTER, BRAKE_AT_SPEED
   } brake_mode_e;

   // Speed events: slot 0..4 speed limits 1-4 and variable, then others
   typedef enum logic [3:0] {
      EV_LIMIT_SL1, EV_LIMIT_SL2, EV_LIMIT_SL3, EV_LIMIT_SL4, EV_LIMIT_VAR,
      EV_LIMIT_MAX, EV_LIMIT_RAMPED, EV_LIMIT_ESTOP, EV_MON_START, EV_ZERO_SPEED
   } speed_event_e;

   // Register port
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [31:0] wdata;
   } reg_req_s;

   // Speed monitoring event
   typedef struct packed {
      logic         valid;
      speed_event_e kind;
   } speed_ev_s;

endpackage

// file: rtl/mute_timer.sv
// Counts a mute interval down and holds the trip back until it ends
module mute_timer #(
   parameter int W = 16
) (
   // Clock and reset
   input  wire logic         clk_sys_i,
   input  wire logic         sys_rst_i,
   // Control
   input  wire logic         start_i,
   input  wire logic [W-1:0] cycles_i,
   input  wire logic         over_limit_i,
   // Result
   output logic              muting_o,
   output logic              trip_o
);
   initial if (W < 2) $error("mute_timer width too small");

   typedef struct packed {
      logic [W-1:0] count;
      logic         muting;
      logic         trip;
   } mute_state_s;

   mute_state_s state_q, state_d;

   // Load on event, count down, trip only after expiry
   always_comb
   begin
      state_d      = state_q;
      state_d.trip = 1'b0;
      if (start_i)
      begin
         state_d.count  = cycles_i;
         state_d.muting = (cycles_i != '0);
         state_d.trip   = (cycles_i == '0) && over_limit_i;
      end
      else if (state_q.muting)
      begin
         state_d.count = state_q.count - 1'b1;
         if (state_q.count == {{(W-1){1'b0}}, 1'b1})
         begin
            state_d.muting = 1'b0;
            state_d.trip   = over_limit_i;
         end
      end
      else
         state_d.trip = over_limit_i;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
         state_q <= '0;
      else
         state_q <= state_d;
   end

   assign muting_o = state_q.muting;
   assign trip_o   = state_q.trip;

   // No trip while muting
   mute_hold_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      muting_o |-> !trip_o)
      else $error("trip raised during mute");

endmodule // mute_timer

// file: rtl/safety_cascade.sv
// How it works
// - Ring holds at most six modules, one neighbour on each side.
// - Local trigger drives cascade output; incoming trigger from previous module triggers too.
// - Without fieldbus only dual-input functions may be cascaded.
// - Single-input functions cascade only when requested over the safety fieldbus.
// - Each loop pairs one dedicated input with one dedicated output.
// - One module is master, the rest are followers.
// - Followers acknowledge automatically; acknowledgement starts at the master.
// - One or two independent loops, each carrying a different function.
// - Any torque removal also asserts the cascaded emergency-stop output.
// - Ramped stop on a torque-controlled follower forces speed control.
// - Estimated speed: transient mute covers limit, start and zero events.
// - Per-function mutes off by default; limit hits use transient mute.
// - Speed-limit mute enable gives limits 1-4 and variable their own mute.
// - Separate enable selects dedicated mute for maximum-speed limit hits.
// - Per-function mutes are independent and may exceed transient mute.
// - Estimated speed: start and zero events always use transient mute.
// - Encoder: limit transient, zero uses zero delay, start uses start delay.
// - Encoder ignores per-function mute times.
// - Ramped and emergency stop limit hits always use transient mute.
// - Torque removal opens the drive torque-off circuit.
// - Brake activates before, with, after torque removal, or at speed limit.
// - Ramp monitor, stop limit hits or fail-safe trigger torque removal.
//
// Added by the designer: strobed register access and the placing of the registers.
module safety_cascade
   import cascade_pkg::*;
#(
   parameter int RING_SIZE = RING_MAX_MODULES
) (
   // Clock and reset
   input  wire logic                     clk_sys_i,
   input  wire logic                     sys_rst_i,
   // Register port
   input  wire cascade_pkg::reg_req_s    reg_req_i,
   output logic [31:0]                   reg_rdata_o,
   // Cascade link, one input and output per loop
   input  wire logic [1:0]               cascade_in_i,
   output logic [1:0]                    cascade_out_o,
   // Local function requests and acknowledge
   input  wire logic [13:0]              fn_request_i,
   input  wire logic [13:0]              fn_from_fieldbus_i,
   input  wire logic                     ack_request_i,
   // Internal trigger sources
   input  wire logic                     ramp_zero_hit_i,
   input  wire logic                     ramp_one_hit_i,
   input  wire logic                     fail_safe_i,
   input  wire logic                     brake_speed_reached_i,
   input  wire logic                     torque_control_i,
   // Speed monitoring
   input  wire cascade_pkg::speed_ev_s   speed_ev_i,
   input  wire logic                     over_limit_i,
   // Drive side
   output logic                          torque_removal_o,
   output logic                          brake_control_o,
   output logic                          force_speed_ctrl_o,
   output logic                          speed_trip_o,
   output logic                          muting_o
);
   import cascade_pkg::*;

   initial if (RING_SIZE < 2 || RING_SIZE > RING_MAX_MODULES)
      $error("cascade ring size out of range");

   typedef struct packed {
      logic [31:0]          config_r;
      logic [7:0]           loop_fn;
      logic [MUTE_W-1:0]    transient;
      logic [MUTE_W-1:0]    zero_dly;
      logic [MUTE_W-1:0]    start_dly;
      logic [MUTE_W-1:0]    max_mute;
      logic [LIMIT_SLOTS*MUTE_W-1:0] limit_mute;
      logic [1:0]           latched;
      logic                 torque_off;
      logic                 brake;
      logic [MUTE_W-1:0]    brake_cnt;
      logic                 force_speed;
      logic [1:0]           cas_out;
      logic [31:0]          rdata;
      logic                 ack_pending;
   } top_state_s;

   top_state_s state_q, state_d;

   logic              mute_start;
   logic [MUTE_W-1:0] mute_cycles;
   logic              muting_w;
   logic              trip_w;

   // Dual-input functions may cascade without fieldbus
   function automatic logic dual_input(input logic [3:0] fn);
      dual_input = (fn <= 4'(FN_DIR_NEG));
   endfunction

   // Permission to cascade a loop's function
   function automatic logic may_cascade(input logic [3:0] fn, input logic fb_cfg,
                                        input logic [13:0] fb_req);
      if (dual_input(fn))
         may_cascade = 1'b1;
      else
         may_cascade = fb_cfg && fb_req[fn];
   endfunction

   // Register address to word
   function automatic logic is_addr(input logic [7:0] a, input logic [7:0] ofs);
      is_addr = (a == ofs);
   endfunction

   // Mute selection
   always_comb
   begin
      mute_start  = speed_ev_i.valid;
      mute_cycles = state_q.transient;
      if (state_q.config_r[CFG_ENCODER_BIT])
      begin
         // Per-function mutes ignored with encoder
         if (speed_ev_i.kind == EV_ZERO_SPEED)
            mute_cycles = state_q.zero_dly;
         else if (speed_ev_i.kind == EV_MON_START)
            mute_cycles = state_q.start_dly;
      end
      else if (speed_ev_i.kind <= EV_LIMIT_VAR &&
               state_q.config_r[CFG_SLS_MUTE_EN_BIT])
         mute_cycles = state_q.limit_mute[speed_ev_i.kind*MUTE_W +: MUTE_W];
      else if (speed_ev_i.kind == EV_LIMIT_MAX &&
               state_q.config_r[CFG_MAX_MUTE_EN_BIT])
         mute_cycles = state_q.max_mute;
      // Ramped and emergency stop, start and zero keep transient
   end

   mute_timer #(
      .W (MUTE_W)
   ) u_mute (
      .clk_sys_i    (clk_sys_i),
      .sys_rst_i    (sys_rst_i),
      .start_i      (mute_start),
      .cycles_i     (mute_cycles),
      .over_limit_i (over_limit_i),
      .muting_o     (muting_w),
      .trip_o       (trip_w)
   );

   logic [1:0] loop_en;
   logic [1:0] local_trig;
   logic       torque_req;
   logic       estop_trig;
   logic       is_master;
   logic       ack_ok;

   // Trigger and cascade logic
   always_comb
   begin
      state_d    = state_q;
      is_master  = state_q.config_r[CFG_MASTER_BIT];
      loop_en    = {state_q.config_r[CFG_LOOP1_EN_BIT] &&
                    state_q.loop_fn[7:4] != state_q.loop_fn[3:0], 1'b1};
      // Followers always auto-acknowledge; master uses its auto-ack bit or its request
      ack_ok     = is_master ? (state_q.config_r[CFG_AUTO_ACK_BIT] || ack_request_i)
                             : 1'b1;
      estop_trig = 1'b0;
      torque_req = fn_request_i[FN_TORQUE_REMOVAL] || ramp_zero_hit_i || ramp_one_hit_i
                   || fail_safe_i || trip_w;
      for (int l = 0; l < LOOP_COUNT; l++)
      begin
         local_trig[l] = loop_en[l] && fn_request_i[state_q.loop_fn[l*4 +: 4]] &&
                         may_cascade(state_q.loop_fn[l*4 +: 4],
                                     state_q.config_r[CFG_FIELDBUS_BIT], fn_from_fieldbus_i);
         if (state_q.loop_fn[l*4 +: 4] == 4'(FN_EMERGENCY_STOP) && loop_en[l])
            estop_trig = 1'b1;
      end
      // Incoming trigger from ring; followers act on it
      for (int l = 0; l < LOOP_COUNT; l++)
      begin
         if (local_trig[l] || (loop_en[l] && cascade_in_i[l]))
            state_d.latched[l] = 1'b1;
         else if (state_q.latched[l] && ack_ok && (is_master || !cascade_in_i[l]))
            state_d.latched[l] = 1'b0;
         state_d.cas_out[l] = loop_en[l] && (local_trig[l] || state_d.latched[l]);
         if (estop_trig && state_q.loop_fn[l*4 +: 4] == 4'(FN_EMERGENCY_STOP)
             && state_d.torque_off)
            state_d.cas_out[l] = 1'b1;
         if (state_q.loop_fn[l*4 +: 4] == 4'(FN_TORQUE_REMOVAL) && state_d.latched[l])
            torque_req = 1'b1;
      end
      // Emergency or ramped stop limit hit cascades into torque removal
      if (trip_w && (speed_ev_i.kind == EV_LIMIT_ESTOP || speed_ev_i.kind == EV_LIMIT_RAMPED))
         torque_req = 1'b1;
      if (torque_req)
         state_d.torque_off = 1'b1;
      else if (ack_ok && !fail_safe_i)
         state_d.torque_off = 1'b0;
      // Brake timing
      case (brake_mode_e'(state_q.config_r[CFG_BRAKE_LSB +: 2]))
         BRAKE_BEFORE:   state_d.brake = torque_req || state_q.torque_off;
         BRAKE_WITH:     state_d.brake = state_d.torque_off;
         BRAKE_AFTER:
         begin
            if (!state_q.torque_off)
               state_d.brake_cnt = state_q.zero_dly;
            else if (state_q.brake_cnt != '0)
               state_d.brake_cnt = state_q.brake_cnt - 1'b1;
            state_d.brake = state_q.torque_off && state_q.brake_cnt == '0;
         end
         BRAKE_AT_SPEED: state_d.brake = state_q.torque_off &&
                                         (brake_speed_reached_i || state_q.brake);
      endcase
      // Ramped stop on torque-controlled follower
      state_d.force_speed = !is_master && torque_control_i &&
                            (fn_request_i[FN_RAMPED_STOP] ||
                             fn_request_i[FN_EMERGENCY_STOP] ||
                             (|(state_q.latched & loop_en)));
      // Register writes
      if (reg_req_i.wr)
      begin
         if (is_addr(reg_req_i.addr, OFS_CONFIG))
            state_d.config_r = reg_req_i.wdata;
         else if (is_addr(reg_req_i.addr, OFS_LOOP_FN))
            state_d.loop_fn = reg_req_i.wdata[7:0];
         else if (is_addr(reg_req_i.addr, OFS_TRANSIENT))
            state_d.transient = reg_req_i.wdata[MUTE_W-1:0];
         else if (is_addr(reg_req_i.addr, OFS_ZERO_DLY))
            state_d.zero_dly = reg_req_i.wdata[MUTE_W-1:0];
         else if (is_addr(reg_req_i.addr, OFS_START_DLY))
            state_d.start_dly = reg_req_i.wdata[MUTE_W-1:0];
         else if (is_addr(reg_req_i.addr, OFS_MAX_MUTE))
            state_d.max_mute = reg_req_i.wdata[MUTE_W-1:0];
         else
            for (int s = 0; s < LIMIT_SLOTS; s++)
               if (is_addr(reg_req_i.addr, OFS_LIMIT_MUTE + 8'(4*s)))
                  state_d.limit_mute[s*MUTE_W +: MUTE_W] = reg_req_i.wdata[MUTE_W-1:0];
      end
      // Register reads, one cycle later
      state_d.rdata = 32'h0000_0000;
      if (reg_req_i.rd)
      begin
         if (is_addr(reg_req_i.addr, OFS_CONFIG))
            state_d.rdata = state_q.config_r;
         else if (is_addr(reg_req_i.addr, OFS_LOOP_FN))
            state_d.rdata = {24'h000000, state_q.loop_fn};
         else if (is_addr(reg_req_i.addr, OFS_TRANSIENT))
            state_d.rdata = {16'h0000, state_q.transient};
         else if (is_addr(reg_req_i.addr, OFS_ZERO_DLY))
            state_d.rdata = {16'h0000, state_q.zero_dly};
         else if (is_addr(reg_req_i.addr, OFS_START_DLY))
            state_d.rdata = {16'h0000, state_q.start_dly};
         else if (is_addr(reg_req_i.addr, OFS_MAX_MUTE))
            state_d.rdata = {16'h0000, state_q.max_mute};
         else if (is_addr(reg_req_i.addr, OFS_STATUS))
            state_d.rdata = {24'h000000, muting_w, state_q.force_speed, state_q.brake,
                             state_q.torque_off, state_q.cas_out, state_q.latched};
         else
            for (int s = 0; s < LIMIT_SLOTS; s++)
               if (is_addr(reg_req_i.addr, OFS_LIMIT_MUTE + 8'(4*s)))
                  state_d.rdata = {16'h0000, state_q.limit_mute[s*MUTE_W +: MUTE_W]};
      end
   end

   // State register
   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
      begin
         state_q            <= '0;
         state_q.config_r   <= CONFIG_RST;
         state_q.loop_fn    <= {4'(FN_START_GUARD), 4'(FN_EMERGENCY_STOP)};
         state_q.transient  <= MUTE_RST;
         state_q.zero_dly   <= MUTE_RST;
         state_q.start_dly  <= MUTE_RST;
         state_q.max_mute   <= MUTE_RST;
         state_q.limit_mute <= {LIMIT_SLOTS{MUTE_RST}};
         state_q.torque_off <= 1'b1;
      end
      else
         state_q <= state_d;
   end

   // Outputs
   assign reg_rdata_o        = state_q.rdata;
   assign cascade_out_o      = state_q.cas_out;
   assign torque_removal_o   = state_q.torque_off;
   assign brake_control_o    = state_q.brake;
   assign force_speed_ctrl_o = state_q.force_speed;
   assign speed_trip_o       = trip_w;
   assign muting_o           = muting_w;

   // Fail-safe forces torque off next cycle
   failsafe_off_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      fail_safe_i |=> torque_removal_o)
      else $error("fail-safe did not remove torque");

   // Incoming ring trigger reaches output
   ring_pass_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      cascade_in_i[0] |=> cascade_out_o[0])
      else $error("ring trigger not passed on");

   // Torque removal with estop loop drives cascade
   estop_follow_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      (state_q.loop_fn[3:0] == 4'(FN_EMERGENCY_STOP) && fn_request_i[FN_TORQUE_REMOVAL])
      |=> cascade_out_o[0])
      else $error("torque removal did not cascade estop");

   // Brake with torque mode follows torque off
   brake_with_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      (state_q.config_r[CFG_BRAKE_LSB +: 2] == 2'h1 && $stable(state_q.config_r))
      |-> brake_control_o == torque_removal_o)
      else $error("brake not aligned with torque removal");

   // Encoder zero event uses zero delay
   enc_zero_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      (speed_ev_i.valid && state_q.config_r[CFG_ENCODER_BIT] &&
       speed_ev_i.kind == EV_ZERO_SPEED) |-> mute_cycles == state_q.zero_dly)
      else $error("wrong zero-speed delay");

   // Stop limit hits use transient mute
   stop_mute_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      (speed_ev_i.valid && (speed_ev_i.kind == EV_LIMIT_ESTOP ||
       speed_ev_i.kind == EV_LIMIT_RAMPED)) |-> mute_cycles == state_q.transient)
      else $error("stop limit hit used wrong mute");

   // Start event without encoder uses transient
   est_start_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      (speed_ev_i.valid && !state_q.config_r[CFG_ENCODER_BIT] &&
       speed_ev_i.kind == EV_MON_START) |-> mute_cycles == state_q.transient)
      else $error("start event used wrong mute");

   // Max speed mute when enabled
   max_mute_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      (speed_ev_i.valid && !state_q.config_r[CFG_ENCODER_BIT] &&
       state_q.config_r[CFG_MAX_MUTE_EN_BIT] && speed_ev_i.kind == EV_LIMIT_MAX)
      |-> mute_cycles == state_q.max_mute)
      else $error("max speed mute not selected");

   // Master never forces speed control
   master_speed_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      ($past(is_master) && $stable(state_q.config_r)) |-> !force_speed_ctrl_o)
      else $error("master forced speed control");

   // Speed-limit hits take their own mute when enabled
   sls_mute_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      (speed_ev_i.valid && !state_q.config_r[CFG_ENCODER_BIT] &&
       state_q.config_r[CFG_SLS_MUTE_EN_BIT] && speed_ev_i.kind <= EV_LIMIT_VAR)
      |-> mute_cycles == state_q.limit_mute[speed_ev_i.kind*MUTE_W +: MUTE_W])
      else $error("speed-limit mute not selected");

   // Encoder limit hits ignore per-function mutes
   enc_limit_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      (speed_ev_i.valid && state_q.config_r[CFG_ENCODER_BIT] &&
       speed_ev_i.kind <= EV_LIMIT_MAX) |-> mute_cycles == state_q.transient)
      else $error("encoder limit hit used wrong mute");

   // Single-input loop stays quiet without fieldbus
   single_block_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      (!state_q.config_r[CFG_FIELDBUS_BIT] && state_q.loop_fn[3:0] > 4'(FN_DIR_NEG) &&
       !cascade_in_i[0] && !state_q.latched[0]) |=> !cascade_out_o[0])
      else $error("single-input function cascaded without fieldbus");

endmodule // safety_cascade

// file: tb/ring_neighbour.sv
// Rest of the ring: passes the trigger on and may start one itself
module ring_neighbour
   import cascade_pkg::*;
#(
   parameter int HOPS = RING_MAX_MODULES - 1
) (
   // Clock and reset
   input  wire logic       clk_sys_i,
   input  wire logic       sys_rst_i,
   // Ring side
   input  wire logic [1:0] trig_out_i,
   input  wire logic [1:0] inject_i,
   output logic      [1:0] trig_in_o,
   output logic      [1:0] feedback_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] hop_q [HOPS];
   // One module per cycle; the last drives feedback_o and does not feed the first again
   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
      begin
         hop_q <= '{default: 2'h0};
      end
      else
      begin
         hop_q[0] <= trig_out_i;
         for (int i = 1; i < HOPS; i++)
         begin
            hop_q[i] <= hop_q[i-1];
         end
      end
   end
   // Returning trigger ends at the master, so the ring cannot hold itself
   assign feedback_o = hop_q[HOPS-1];
   // Master just ahead of us injects; acknowledge is its business, not ours
   assign trig_in_o = inject_i;
endmodule // ring_neighbour

// file: tb/testbench.sv
module testbench;
   import cascade_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_i, sys_rst_i, ack, r0, r1, fsafe, bspd, tctl, ovl;
   reg_req_s req;
   speed_ev_s ev;
   logic [31:0] rdata;
   logic [13:0] fnr, fnb;
   logic [1:0] cin, cout, inj, fb;
   logic torq, brk, fsc, trip, mute;
   int failures, checks;
   // Clock
   initial
   begin
      clk_sys_i = 0;
      forever #20 clk_sys_i = ~clk_sys_i;
   end
   safety_cascade #(.RING_SIZE(RING_MAX_MODULES)) DUT (.clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i), .reg_req_i(req), .reg_rdata_o(rdata), .cascade_in_i(cin),
      .cascade_out_o(cout), .fn_request_i(fnr), .fn_from_fieldbus_i(fnb),
      .ack_request_i(ack), .ramp_zero_hit_i(r0), .ramp_one_hit_i(r1), .fail_safe_i(fsafe),
      .brake_speed_reached_i(bspd), .torque_control_i(tctl), .speed_ev_i(ev),
      .over_limit_i(ovl), .torque_removal_o(torq), .brake_control_o(brk),
      .force_speed_ctrl_o(fsc), .speed_trip_o(trip), .muting_o(mute));
   ring_neighbour #(.HOPS(RING_MAX_MODULES - 1)) ring (.clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i), .trig_out_i(cout), .inject_i(inj), .trig_in_o(cin),
      .feedback_o(fb));
   // Verdict
   task automatic complete_run();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Register port cycles
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk_sys_i);
      req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_sys_i);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      @(posedge clk_sys_i);
      req.rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask
   // One event, then measure the muted span and the trip after it
   task automatic mute_case(input logic [31:0] cfg, input speed_event_e k, input int n);
      int c;
      c = 0;
      wr(OFS_CONFIG, cfg);
      @(posedge clk_sys_i);
      ev <= '{valid: 1'b1, kind: k};
      @(posedge clk_sys_i);
      ev.valid <= 1'b0;
      #1;
      while (mute === 1'b1 && c < 60)
      begin
         c++;
         @(posedge clk_sys_i);
         #1;
      end
      chk(c, n);
      chk(trip, 1'b1);
   endtask
   task automatic reset_values();
      chk(torq, 1'b0);
      rd(OFS_CONFIG, 32'h0000_0080);
      rd(OFS_LOOP_FN, 32'h0000_00D2);
      rd(OFS_TRANSIENT, 32'h0000_0019);
      rd(8'h30, 32'h0000_0000);
   endtask
   task automatic mute_table();
      ovl <= 1'b1;
      wr(OFS_TRANSIENT, 32'h3);
      wr(OFS_ZERO_DLY, 32'h5);
      wr(OFS_START_DLY, 32'h7);
      wr(OFS_MAX_MUTE, 32'hB);
      for (int k = 0; k < LIMIT_SLOTS; k++)
         wr(OFS_LIMIT_MUTE + 8'(4 * k), 32'(20 + k));
      mute_case(32'h80, EV_LIMIT_SL1, 3);
      mute_case(32'h80, EV_ZERO_SPEED, 3);
      mute_case(32'h80, EV_MON_START, 3);
      for (int k = 0; k < LIMIT_SLOTS; k++)
         mute_case(32'h88, speed_event_e'(k), 20 + k);
      mute_case(32'h88, EV_MON_START, 3);
      mute_case(32'h88, EV_LIMIT_MAX, 3);
      mute_case(32'h98, EV_LIMIT_RAMPED, 3);
      mute_case(32'h98, EV_LIMIT_ESTOP, 3);
      mute_case(32'h90, EV_LIMIT_MAX, 11);
      mute_case(32'h90, EV_LIMIT_SL1, 3);
      mute_case(32'h9C, EV_LIMIT_SL1, 3);
      mute_case(32'h9C, EV_LIMIT_MAX, 3);
      mute_case(32'h9C, EV_ZERO_SPEED, 5);
      mute_case(32'h9C, EV_MON_START, 7);
      wr(OFS_CONFIG, 32'h80);
      ovl <= 1'b0;
   endtask
   task automatic ramped_follower();
      fnr[FN_RAMPED_STOP] <= 1'b1;
      tctl <= 1'b1;
      settle(4);
      chk(fsc, 1'b1);
      fnr[FN_RAMPED_STOP] <= 1'b0;
      tctl <= 1'b0;
   endtask
   task automatic single_input_loop();
      wr(OFS_LOOP_FN, 32'h0000_00D6);
      fnr[FN_SPEED_LIMIT_2] <= 1'b1;
      settle(6);
      chk(cout[0], 1'b0);
      wr(OFS_CONFIG, 32'h82);
      fnb[FN_SPEED_LIMIT_2] <= 1'b1;
      settle(4);
      chk(cout[0], 1'b1);
      fnr[FN_SPEED_LIMIT_2] <= 1'b0;
   endtask
   task automatic ring_trigger();
      @(posedge clk_sys_i);
      inj[1] <= 1'b1;
      settle(2);
      chk(cout[1], 1'b1);
      inj[1] <= 1'b0;
      settle(4);
      chk(fb[1], 1'b1);
   endtask
   // Master holds the loop until its own acknowledge
   task automatic master_ack();
      wr(OFS_LOOP_FN, 32'h0000_00D2);
      wr(OFS_CONFIG, 32'h81);
      fnr[FN_EMERGENCY_STOP] <= 1'b1;
      tctl <= 1'b1;
      settle(3);
      fnr[FN_EMERGENCY_STOP] <= 1'b0;
      settle(3);
      chk(cout[0], 1'b1);
      chk(fsc, 1'b0);
      ack <= 1'b1;
      settle(2);
      chk(cout[0], 1'b0);
      ack <= 1'b0;
      tctl <= 1'b0;
   endtask
   task automatic fail_safe_stop();
      wr(OFS_LOOP_FN, 32'h0000_00D2);
      wr(OFS_CONFIG, 32'hA0);
      r1 <= 1'b1;
      settle(2);
      chk(torq, 1'b1);
      chk(brk, 1'b1);
      r1 <= 1'b0;
      settle(2);
      chk(torq, 1'b0);
      chk(brk, 1'b0);
      fsafe <= 1'b1;
      settle(4);
      chk(torq, 1'b1);
      chk(cout[0], 1'b1);
      chk(brk, 1'b1);
   endtask
   // Main sequence
   initial
   begin
      failures = 0;
      checks = 0;
      req = '0;
      ev = '0;
      {ack, r0, r1, fsafe, bspd, tctl} = '0;
      ovl = 1'b0;
      fnr = '0;
      fnb = '0;
      inj = '0;
      sys_rst_i = 1'b1;
      repeat (11) @(posedge clk_sys_i);
      #1 chk(torq, 1'b1);
      @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      settle(1);
      reset_values();
      mute_table();
      ramped_follower();
      single_input_loop();
      ring_trigger();
      master_ack();
      fail_safe_stop();
      complete_run();
   end
   // Watchdog
   initial
   begin
      #(40 * 20000);
      failures++;
      complete_run();
   end
endmodule // testbench
